// ### rtl/scsilr_pkg.sv
// shared constants for the unit report, sense and reservation link
package scsilr_pkg;
    localparam logic [7:0] OP_REPORT_LUNS = 8'ha0;
    localparam logic [7:0] OP_REQ_SENSE = 8'h03;
    localparam logic [7:0] OP_RESERVE6 = 8'h16;
    localparam logic [7:0] OP_RESERVE10_A = 8'h56;
    localparam logic [7:0] OP_RESERVE10_B = 8'h57;
    localparam logic [7:0] OP_RELEASE6 = 8'h17;
    localparam logic [7:0] OP_RELEASE10 = 8'h57;
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;
    localparam logic [7:0] ST_CONFLICT = 8'h18;
    localparam logic [3:0] KEY_NONE = 4'h0;
    localparam logic [3:0] KEY_ILLEGAL = 4'h5;
    localparam logic [3:0] KEY_ABORTED = 4'hb;
    localparam logic [7:0] ASC_NONE = 8'h00;
    localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
    localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
    localparam logic [7:0] ASC_NO_UNIT = 8'h25;
    localparam logic [7:0] ASC_BUS_FREE = 8'h47;
    localparam logic [31:0] LUN_MIN_ALLOC = 32'h0000_0010;
    localparam logic [5:0] LUN_LIST_BYTES = 6'h10;
    localparam logic [7:0] LUN_LIST_LEN = 8'h08;
    localparam logic [5:0] LUN_LEN_POS = 6'h03;
    localparam logic [7:0] SENSE_MAX = 8'h20;
    localparam logic [7:0] SENSE_CODE = 8'h70;
    localparam logic [7:0] SENSE_ADD_LEN = 8'h18;
    localparam logic [5:0] SENSE_KEY_POS = 6'h02;
    localparam logic [5:0] SENSE_LEN_POS = 6'h07;
    localparam logic [5:0] SENSE_ASC_POS = 6'h0c;
    localparam int NUM_INIT = 8;
    localparam logic [7:0] REG_CDB0 = 8'h00;
    localparam logic [7:0] REG_CDB1 = 8'h04;
    localparam logic [7:0] REG_CDB2 = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_LINK = 8'h14;
    localparam logic [7:0] REG_DATA = 8'h20;
    localparam logic [7:0] REG_DATA_END = 8'h3c;
    localparam logic [1:0] REG_DATA_POS = 2'h2;
    localparam int CTRL_GO = 0;
    localparam int CTRL_ID_POS = 4;
    localparam int CTRL_LUN_POS = 8;
    localparam int LINK_BUS_RESET = 0;
    localparam int LINK_TGT_RESET = 1;
    localparam int LINK_BUS_FREE = 2;
endpackage

// ### rtl/scsilr_link_if.sv
// command, data and status link between initiator and target
interface scsilr_link_if;
    logic cmd_valid;
    logic cmd_ready;
    logic [95:0] cmd_cdb;
    logic [2:0] cmd_initiator;
    logic [2:0] cmd_lun;
    logic data_valid;
    logic data_ready;
    logic [7:0] data_byte;
    logic status_valid;
    logic [7:0] status_code;
    logic bus_reset;
    logic target_reset;
    logic bus_free_err;
    logic [2:0] bus_free_initiator;
    modport dev (input cmd_valid, cmd_cdb, cmd_initiator, cmd_lun, data_ready, bus_reset, target_reset,
        bus_free_err, bus_free_initiator, output cmd_ready, data_valid, data_byte, status_valid, status_code);
    modport ini (output cmd_valid, cmd_cdb, cmd_initiator, cmd_lun, data_ready, bus_reset, target_reset,
        bus_free_err, bus_free_initiator, input cmd_ready, data_valid, data_byte, status_valid, status_code);
endinterface

// ### rtl/scsilr_target.sv
// target end: unit report, sense retrieval and whole-unit reservation
// Behaviour
// - opcode a0h, twelve bytes, returns unit list
// - unit report ignores every reservation
// - unit report allocation below 16 is checked
// - short allocation sends no data, check status
// - list length 8, reserved, unit zero entry
// - only unit zero exists
// - opcode 03h, allocation byte 4, returns sense
// - sense kept after check or bus free
// - sense on bad unit: good, unit unsupported
// - nothing pending gives no sense
// - next command from same path clears sense
// - one sense store per initiator
// - sense length is min(allocation, 32)
// - opcode 16h reserves whole unit
// - reservation ends on supersede, release, resets
// - on-behalf flag selects reservation holder
// - ten-byte reserve decoded as 56h and 57h
// - ten-byte extent bit set is checked
// - identification and extent length ignored
// - on-behalf own id equals plain reserve
// - only issuer releases; new grant supersedes
// - other initiator reserving gets conflict
// - release with nothing reserved is good
//
// Decided for this implementation: the register addresses and the Avalon-MM interface to the registers.
module scsilr_target
    import scsilr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    scsilr_link_if.dev link,
    output logic resv_active,
    output logic [2:0] resv_owner,
    output logic [2:0] resv_holder
);
    typedef enum logic [2:0] {
        SCSILR_IDLE = 3'b001,
        SCSILR_DATA = 3'b010,
        SCSILR_STAT = 3'b100
    } scsilr_state_t;

    function automatic logic [7:0] cdb_byte(input logic [95:0] cdb, input int i);
        cdb_byte = cdb[95 - 8 * i -: 8];
    endfunction

    function automatic logic [7:0] out_byte(input logic list, input logic [5:0] idx, input logic [3:0] key,
        input logic [7:0] asc);
        out_byte = 8'h00;
        if (list && idx == LUN_LEN_POS)
            out_byte = LUN_LIST_LEN;
        else if (!list && idx == 6'h00)
            out_byte = SENSE_CODE;
        else if (!list && idx == SENSE_KEY_POS)
            out_byte = {4'h0, key};
        else if (!list && idx == SENSE_LEN_POS)
            out_byte = SENSE_ADD_LEN;
        else if (!list && idx == SENSE_ASC_POS)
            out_byte = asc;
    endfunction

    scsilr_state_t state;
    logic [NUM_INIT-1:0] pending;
    logic [3:0] store_key [NUM_INIT];
    logic [7:0] store_asc [NUM_INIT];
    logic x_list;
    logic [3:0] x_key;
    logic [7:0] x_asc;
    logic [5:0] x_len;
    logic [5:0] idx;
    logic [7:0] data_q;
    logic [7:0] status_q;

    wire [7:0] op = cdb_byte(link.cmd_cdb, 0);
    wire [7:0] b1 = cdb_byte(link.cmd_cdb, 1);
    wire [7:0] b3 = cdb_byte(link.cmd_cdb, 3);
    wire [7:0] rs_alloc = cdb_byte(link.cmd_cdb, 4);
    wire [31:0] rl_alloc = {cdb_byte(link.cmd_cdb, 6), cdb_byte(link.cmd_cdb, 7),
        cdb_byte(link.cmd_cdb, 8), cdb_byte(link.cmd_cdb, 9)};
    wire [2:0] me = link.cmd_initiator;
    wire accept = link.cmd_valid && link.cmd_ready;
    wire is_rl = op == OP_REPORT_LUNS;
    wire is_rs = op == OP_REQ_SENSE;
    wire is_r6 = op == OP_RESERVE6;
    // both printed codes reserve; 57h is shared with the ten-byte release
    wire is_r10 = op == OP_RESERVE10_A || op == OP_RESERVE10_B;
    wire is_rel = op == OP_RELEASE6;
    wire lun_bad = link.cmd_lun != 3'h0;
    // identification byte and extent length never looked at
    wire ext_bit = b1[0];
    wire on_behalf_flag = b1[4];
    wire [2:0] on_behalf_target_id = is_r10 ? b3[2:0] : b1[3:1];
    // own id as third party gives the same holder as a plain reserve
    wire [2:0] new_holder = on_behalf_flag ? on_behalf_target_id : me;
    // no queuing: any other owner conflicts at once
    wire conflict = resv_active && resv_owner != me;
    wire rl_short = rl_alloc < LUN_MIN_ALLOC;
    wire [5:0] rs_len = rs_alloc > SENSE_MAX ? SENSE_MAX[5:0] : rs_alloc[5:0];
    wire is_resv = is_r6 || is_r10;
    wire grant = !is_rl && !is_rs && !lun_bad && is_resv && !ext_bit && !conflict;
    // release acts only for the owner, else good and unchanged
    wire drop = !lun_bad && is_rel && resv_active && resv_owner == me;

    logic [7:0] next_status;
    logic [3:0] next_key;
    logic [7:0] next_asc;
    always_comb begin
        next_status = ST_GOOD;
        next_key = KEY_NONE;
        next_asc = ASC_NONE;
        // unit report is decided before reservation or unit checks
        if (is_rl) begin
            if (rl_short) begin
                next_status = ST_CHECK;
                next_key = KEY_ILLEGAL;
                next_asc = ASC_BAD_FIELD;
            end
        end else if (is_rs) begin
            next_status = ST_GOOD;
        end else if (lun_bad) begin
            next_status = ST_CHECK;
            next_key = KEY_ILLEGAL;
            next_asc = ASC_NO_UNIT;
        end else if (is_resv) begin
            // extent bit rejected before conflict check
            if (ext_bit) begin
                next_status = ST_CHECK;
                next_key = KEY_ILLEGAL;
                next_asc = ASC_BAD_FIELD;
            end else if (conflict) begin
                next_status = ST_CONFLICT;
            end
        end else if (!is_rel) begin
            next_status = ST_CHECK;
            next_key = KEY_ILLEGAL;
            next_asc = ASC_BAD_OPCODE;
        end
    end

    // pick the sense image for a retrieval
    wire [3:0] rs_key = lun_bad ? KEY_ILLEGAL : (pending[me] ? store_key[me] : KEY_NONE);
    wire [7:0] rs_asc = lun_bad ? ASC_NO_UNIT : (pending[me] ? store_asc[me] : ASC_NONE);
    // an allocation of at least 16 always holds the single entry
    wire [5:0] load_len = is_rl ? (rl_short ? 6'h00 : LUN_LIST_BYTES) : (is_rs ? rs_len : 6'h00);
    wire [5:0] next_idx = state == SCSILR_IDLE ? 6'h00 : idx + 6'h01;
    wire last = idx == x_len - 6'h01;

    assign link.cmd_ready = state == SCSILR_IDLE;
    assign link.data_valid = state == SCSILR_DATA;
    assign link.status_valid = state == SCSILR_STAT;
    assign link.data_byte = data_q;
    assign link.status_code = status_q;

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= SCSILR_IDLE;
            idx <= 6'h00;
            x_list <= 1'b0;
            x_key <= KEY_NONE;
            x_asc <= ASC_NONE;
            x_len <= 6'h00;
            status_q <= ST_GOOD;
        end else begin
            unique case (state)
                SCSILR_IDLE: begin
                    if (accept) begin
                        // latch what is to be sent
                        x_list <= is_rl;
                        x_key <= rs_key;
                        x_asc <= rs_asc;
                        x_len <= load_len;
                        idx <= 6'h00;
                        status_q <= next_status;
                        state <= load_len != 6'h00 ? SCSILR_DATA : SCSILR_STAT;
                    end
                end
                SCSILR_DATA: begin
                    if (link.data_ready) begin
                        idx <= next_idx;
                        if (last)
                            state <= SCSILR_STAT;
                    end
                end
                SCSILR_STAT: state <= SCSILR_IDLE;
            endcase
        end
    end

    // byte register runs one index ahead of the handshake
    always_ff @(posedge clock) begin
        if (reset)
            data_q <= 8'h00;
        else if (accept)
            data_q <= out_byte(is_rl, 6'h00, rs_key, rs_asc);
        else if (state == SCSILR_DATA && link.data_ready)
            data_q <= out_byte(x_list, next_idx, x_key, x_asc);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pending <= '0;
            for (int i = 0; i < NUM_INIT; i++) begin
                store_key[i] <= KEY_NONE;
                store_asc[i] <= ASC_NONE;
            end
        end else begin
            if (accept) begin
                // every command clears, a new check refills
                pending[me] <= next_status == ST_CHECK;
                store_key[me] <= next_key;
                store_asc[me] <= next_asc;
            end
            // lost bus phase leaves sense; set beats a same-cycle clear
            if (link.bus_free_err) begin
                pending[link.bus_free_initiator] <= 1'b1;
                store_key[link.bus_free_initiator] <= KEY_ABORTED;
                store_asc[link.bus_free_initiator] <= ASC_BUS_FREE;
            end
        end
    end

    always_ff @(posedge clock) begin
        // power, bus reset and target reset drop the reservation
        if (reset || link.bus_reset || link.target_reset) begin
            resv_active <= 1'b0;
            resv_owner <= 3'h0;
            resv_holder <= 3'h0;
        end else if (accept && grant) begin
            // new grant replaces the old one
            resv_active <= 1'b1;
            resv_owner <= me;
            resv_holder <= new_holder;
        end else if (accept && drop) begin
            resv_active <= 1'b0;
        end
    end
endmodule

// ### rtl/scsilr_initiator.sv
// initiator end: Avalon-MM registers drive commands over the link
module scsilr_initiator
    import scsilr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    scsilr_link_if.ini link,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    typedef enum logic [2:0] {
        SCSILR_I_IDLE = 3'b001,
        SCSILR_I_SEND = 3'b010,
        SCSILR_I_RECV = 3'b100
    } scsilr_istate_t;

    scsilr_istate_t state;
    logic [31:0] cdb_w [3];
    logic [2:0] my_id;
    logic [2:0] my_lun;
    logic done;
    logic [7:0] status_q;
    logic [5:0] count;
    logic [7:0] buffer [32];
    logic ack;
    logic bus_reset_q;
    logic target_reset_q;
    logic bus_free_q;

    // one wait state per access; data is prepared while waiting
    wire req = avs_read || avs_write;
    wire take = req && ack;
    wire wr_ctrl = avs_write && ack && avs_address == REG_CTRL;
    wire wr_link = avs_write && ack && avs_address == REG_LINK;
    wire go = wr_ctrl && avs_writedata[CTRL_GO] && state == SCSILR_I_IDLE;
    wire is_data = avs_address >= REG_DATA && avs_address <= REG_DATA_END;
    wire [2:0] word_sel = avs_address[4:2];
    wire [31:0] data_word = {buffer[{word_sel, 2'h3}], buffer[{word_sel, 2'h2}],
        buffer[{word_sel, 2'h1}], buffer[{word_sel, 2'h0}]};

    logic [31:0] next_readdata;
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (avs_address == REG_CDB0)
            next_readdata = cdb_w[0];
        else if (avs_address == REG_CDB1)
            next_readdata = cdb_w[1];
        else if (avs_address == REG_CDB2)
            next_readdata = cdb_w[2];
        else if (avs_address == REG_CTRL)
            next_readdata = {21'h0, my_lun, 1'b0, my_id, 4'h0};
        else if (avs_address == REG_STATUS)
            next_readdata = {10'h0, count, status_q, 6'h0, done, state != SCSILR_I_IDLE};
        else if (is_data)
            next_readdata = data_word;
    end

    assign avs_waitrequest = req && !ack;
    // cdb byte 4w+k sits at bits 8k+7:8k of word w
    assign link.cmd_cdb = {cdb_w[0][7:0], cdb_w[0][15:8], cdb_w[0][23:16], cdb_w[0][31:24],
        cdb_w[1][7:0], cdb_w[1][15:8], cdb_w[1][23:16], cdb_w[1][31:24],
        cdb_w[2][7:0], cdb_w[2][15:8], cdb_w[2][23:16], cdb_w[2][31:24]};
    assign link.cmd_valid = state == SCSILR_I_SEND;
    assign link.cmd_initiator = my_id;
    assign link.cmd_lun = my_lun;
    assign link.data_ready = state == SCSILR_I_RECV;
    assign link.bus_reset = bus_reset_q;
    assign link.target_reset = target_reset_q;
    assign link.bus_free_err = bus_free_q;
    assign link.bus_free_initiator = my_id;

    always_ff @(posedge clock) begin
        if (reset) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack <= req && !ack;
            if (avs_read && !ack)
                avs_readdata <= next_readdata;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            for (int i = 0; i < 3; i++)
                cdb_w[i] <= 32'h0000_0000;
            my_id <= 3'h0;
            my_lun <= 3'h0;
            bus_reset_q <= 1'b0;
            target_reset_q <= 1'b0;
            bus_free_q <= 1'b0;
        end else begin
            // cdb is frozen while a command is out
            if (avs_write && ack && state == SCSILR_I_IDLE && avs_address <= REG_CDB2)
                cdb_w[avs_address[3:2]] <= avs_writedata;
            if (wr_ctrl && state == SCSILR_I_IDLE) begin
                my_id <= avs_writedata[CTRL_ID_POS +: 3];
                my_lun <= avs_writedata[CTRL_LUN_POS +: 3];
            end
            if (wr_link)
                bus_reset_q <= avs_writedata[LINK_BUS_RESET];
            target_reset_q <= wr_link && avs_writedata[LINK_TGT_RESET];
            bus_free_q <= wr_link && avs_writedata[LINK_BUS_FREE];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= SCSILR_I_IDLE;
            done <= 1'b0;
            status_q <= 8'h00;
            count <= 6'h00;
            for (int i = 0; i < 32; i++)
                buffer[i] <= 8'h00;
        end else begin
            unique case (state)
                SCSILR_I_IDLE: begin
                    if (go) begin
                        done <= 1'b0;
                        count <= 6'h00;
                        state <= SCSILR_I_SEND;
                    end
                end
                SCSILR_I_SEND: begin
                    if (link.cmd_ready)
                        state <= SCSILR_I_RECV;
                end
                SCSILR_I_RECV: begin
                    // more than 32 bytes cannot occur; the target clips
                    if (link.data_valid && count < 6'h20) begin
                        buffer[count[4:0]] <= link.data_byte;
                        count <= count + 6'h01;
                    end
                    if (link.status_valid) begin
                        status_q <= link.status_code;
                        done <= 1'b1;
                        state <= SCSILR_I_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ### tb/scsilr_chk.sv
// link assertions between the initiator and target ends
module scsilr_chk
    import scsilr_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [95:0] cmd_cdb,
    input wire logic [2:0] cmd_lun,
    input wire logic data_valid,
    input wire logic data_ready,
    input wire logic [7:0] data_byte,
    input wire logic status_valid,
    input wire logic [7:0] status_code
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [7:0] op;
    logic [7:0] alloc;
    logic [5:0] cnt;
    wire acc = cmd_valid && cmd_ready;
    wire [7:0] cop = cmd_cdb[95:88];
    wire [31:0] lalloc = cmd_cdb[47:16];
    // byte count restarts at every accepted command
    always_ff @(posedge clock) begin
        if (reset || acc)
            cnt <= 6'h00;
        else if (data_valid && data_ready)
            cnt <= cnt + 6'h01;
    end
    always_ff @(posedge clock) begin
        if (acc) begin
            op <= cop;
            alloc <= cmd_cdb[63:56];
        end
    end
    sequence s_take(c);
        acc && cop == c;
    endsequence
    sequence s_check;
        status_valid && status_code == ST_CHECK;
    endsequence
    a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_cdb))
        else $error("command changed before accept");
    a_status_pulse: assert property (status_valid |=> !status_valid)
        else $error("status pulse longer than one cycle");
    a_data_hold: assert property (data_valid && !data_ready |=> data_valid && $stable(data_byte))
        else $error("data byte dropped before taken");
    a_lun_start: assert property (s_take(OP_REPORT_LUNS) ##0 lalloc >= LUN_MIN_ALLOC |=> data_valid)
        else $error("unit report did not start data");
    a_lun_short: assert property (s_take(OP_REPORT_LUNS) ##0 lalloc < LUN_MIN_ALLOC |=> s_check)
        else $error("short unit report not checked");
    a_ext_reject: assert property (s_take(OP_RESERVE10_A) ##0 cmd_cdb[80] |=> s_check)
        else $error("extent reserve not checked");
    a_unit_bad: assert property (acc && cmd_lun != 3'h0 && cop != OP_REPORT_LUNS && cop != OP_REQ_SENSE |=> s_check)
        else $error("command to missing unit not checked");
    a_lun_count: assert property (status_valid && op == OP_REPORT_LUNS && status_code == ST_GOOD |-> cnt == 6'h10)
        else $error("unit list length wrong");
    a_sense_count: assert property (status_valid && op == OP_REQ_SENSE |->
        cnt == (alloc < SENSE_MAX ? alloc[5:0] : 6'h20))
        else $error("sense length wrong");
    a_sense_good: assert property (status_valid && op == OP_REQ_SENSE |-> status_code == ST_GOOD)
        else $error("sense retrieval not good");
endmodule

// ### tb/scsi_lun_sense_reserve_cmds_test.sv
// self-checking bench for the initiator and target pair
module scsi_lun_sense_reserve_cmds_test import scsilr_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic resv_active;
    logic [2:0] resv_owner;
    logic [2:0] resv_holder;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] cdb [12];
    logic [31:0] q;
    logic [7:0] st;
    logic [5:0] cnt;
    `define chk(n, e, g) begin checks++; if ((g) !== (e)) begin \
        miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end
    scsilr_link_if link();
    scsilr_target i_scsilr_target(.clock(clock), .reset(reset), .link(link.dev), .resv_active(resv_active),
        .resv_owner(resv_owner), .resv_holder(resv_holder));
    scsilr_initiator i_scsilr_initiator(.clock(clock), .reset(reset), .link(link.ini), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    scsilr_chk i_scsilr_chk(.clock(clock), .reset(reset), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
        .cmd_cdb(link.cmd_cdb), .cmd_lun(link.cmd_lun), .data_valid(link.data_valid), .data_ready(link.data_ready),
        .data_byte(link.data_byte), .status_valid(link.status_valid), .status_code(link.status_code));
    always #4 clock = ~clock;
    task results;
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // generous ceiling, the full run needs well under two thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            results();
        end
    end
    // request held until the edge that sees waitrequest low; one idle edge keeps strobes single-driven
    task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
        avs_address <= ad;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask
    task mk(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b4);
        foreach (cdb[i]) cdb[i] = 8'h00;
        cdb[0] = op;
        cdb[1] = b1;
        cdb[4] = b4;
    endtask
    task run(input logic [2:0] id, input logic [2:0] lun);
        for (int w = 0; w < 3; w++)
            bus(1'b1, REG_CDB0 + 8'(4 * w), {cdb[4*w+3], cdb[4*w+2], cdb[4*w+1], cdb[4*w]});
        bus(1'b1, REG_CTRL, {21'h0, lun, 1'b0, id, 4'h1});
        do bus(1'b0, REG_STATUS, 32'h0); while (q[1] !== 1'b1);
        st = q[15:8];
        cnt = q[21:16];
    endtask
    function automatic logic [7:0] exp_b(int i, logic s, logic [3:0] k, logic [7:0] c);
        if (!s)
            return (i == 3) ? LUN_LIST_LEN : 8'h00;
        case (i)
            0: return SENSE_CODE;
            2: return {4'h0, k};
            7: return SENSE_ADD_LEN;
            12: return c;
            default: return 8'h00;
        endcase
    endfunction
    task data_chk(input logic s, input logic [3:0] k, input logic [7:0] c, input int n);
        for (int i = 0; i < n; i++) begin
            if (i % 4 == 0)
                bus(1'b0, REG_DATA + 8'(i), 32'h0);
            `chk("data byte", exp_b(i, s, k, c), q[8*(i%4)+:8])
        end
    endtask
    task sense(input logic [2:0] id, input logic [2:0] lun, input logic [7:0] al, input logic [3:0] k,
        input logic [7:0] c);
        logic [5:0] n;
        mk(OP_REQ_SENSE, 8'h00, al);
        run(id, lun);
        n = al < SENSE_MAX ? al[5:0] : 6'h20;
        `chk("sense status", ST_GOOD, st)
        `chk("sense count", n, cnt)
        data_chk(1'b1, k, c, n);
    endtask
    task resv(input logic [7:0] op, input logic [7:0] b1, input logic [2:0] id, input logic [7:0] e, input logic a);
        mk(op, b1, 8'h00);
        cdb[2] = 8'($urandom);
        run(id, 3'h0);
        `chk("resv status", e, st)
        `chk("resv active", a, resv_active)
    endtask
    initial begin
        void'($urandom(32'h826aabe7));
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        for (int a = 0; a < 6; a++) begin
            mk(OP_REPORT_LUNS, 8'h00, 8'h00);
            cdb[9] = (a == 0) ? 8'h10 : 8'($urandom_range(16, 255));
            cdb[6] = (a == 1) ? 8'hff : 8'h00;
            run(3'($urandom), 3'($urandom));
            `chk("lun status", ST_GOOD, st)
            `chk("lun count", LUN_LIST_BYTES, cnt)
            data_chk(1'b0, 4'h0, 8'h00, 16);
        end
        mk(OP_REPORT_LUNS, 8'h00, 8'h00);
        cdb[9] = 8'($urandom_range(0, 15));
        run(3'h2, 3'h0);
        `chk("short status", ST_CHECK, st)
        sense(3'h6, 3'h0, 8'h20, KEY_NONE, ASC_NONE);
        sense(3'h2, 3'h0, 8'h20, KEY_ILLEGAL, ASC_BAD_FIELD);
        sense(3'h2, 3'h0, 8'h20, KEY_NONE, ASC_NONE);
        for (int a = 0; a < 6; a++)
            sense(3'($urandom), 3'h0, (a < 2) ? 8'(a * 33) : 8'($urandom), KEY_NONE, ASC_NONE);
        sense(3'h1, 3'($urandom_range(1, 7)), 8'h20, KEY_ILLEGAL, ASC_NO_UNIT);
        mk(OP_RESERVE6, 8'h00, 8'h00);
        run(3'h3, 3'h2);
        `chk("unit two", ST_CHECK, st)
        resv(OP_RESERVE6, 8'h00, 3'h1, ST_GOOD, 1'b1);
        `chk("holder", 3'h1, resv_holder)
        mk(OP_REPORT_LUNS, 8'h00, 8'h00);
        cdb[9] = 8'h10;
        run(3'h2, 3'h0);
        `chk("report reserved", ST_GOOD, st)
        resv(OP_RESERVE6, 8'h00, 3'h2, ST_CONFLICT, 1'b1);
        resv(OP_RESERVE6, 8'h1a, 3'h1, ST_GOOD, 1'b1);
        `chk("third party", 3'h5, resv_holder)
        `chk("owner", 3'h1, resv_owner)
        resv(OP_RELEASE6, 8'h00, 3'h5, ST_GOOD, 1'b1);
        resv(OP_RELEASE6, 8'h00, 3'h1, ST_GOOD, 1'b0);
        resv(OP_RELEASE6, 8'h00, 3'h1, ST_GOOD, 1'b0);
        resv(OP_RESERVE10_A, 8'h01, 3'h4, ST_CHECK, 1'b0);
        sense(3'h4, 3'h0, 8'h20, KEY_ILLEGAL, ASC_BAD_FIELD);
        mk(OP_RESERVE10_B, 8'h10, 8'h00);
        cdb[3] = 8'h04;
        run(3'h4, 3'h0);
        `chk("own id", 3'h4, resv_holder)
        bus(1'b1, REG_LINK, 32'h2);
        // pulse lands one edge after the write; let it settle
        bus(1'b0, REG_STATUS, 32'h0);
        `chk("target reset", 1'b0, resv_active)
        resv(OP_RESERVE10_A, 8'h00, 3'h6, ST_GOOD, 1'b1);
        bus(1'b1, REG_LINK, 32'h1);
        bus(1'b1, REG_LINK, 32'h0);
        `chk("bus reset", 1'b0, resv_active)
        bus(1'b1, REG_LINK, 32'h4);
        sense(3'h6, 3'h0, 8'h20, KEY_ABORTED, ASC_BUS_FREE);
        results();
    end
endmodule
